// File: act_pkg.sv
package act_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
  // wait resolution is one tick; error bound is one tick, far above this
  localparam int unsigned WAIT_ERR_NS = 200;

  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int NPINS = 24;
  localparam int NTMR = 10;
  localparam int CNT_W = 32;
  localparam int ALM_NF = 6;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_WAIT = 12'h008;
  localparam logic [11:0] OFF_ALM_CLR = 12'h00c;
  localparam logic [11:0] OFF_ALM_BASE = 12'h020;
  localparam logic [11:0] OFF_RT_BASE = 12'h040;
  localparam logic [11:0] OFF_TMR_BASE = 12'h080;
  localparam logic [11:0] OFF_CNT_BASE = 12'h100;
  localparam logic [11:0] OFF_PIN_EN = 12'h180;
  localparam logic [11:0] OFF_PIN_FALL = 12'h184;
  localparam logic [11:0] ALM_SPAN = 12'h018;
  localparam logic [11:0] RT_SPAN = 12'h018;
  localparam logic [11:0] TMR_SPAN = 12'h050;
  localparam logic [11:0] CNT_SPAN = 12'h060;

  // ----------------------------------------------------------------------
  // fields and values
  // ----------------------------------------------------------------------
  localparam int CTRL_RT_RST = 0;
  localparam int ST_ARMED = 0;
  localparam int ST_WAIT = 1;
  localparam int ALM_YEAR = 0;
  localparam logic [31:0] FIELD_UNSET = 32'hffff_ffff;
  localparam logic [9:0] MS_MAX = 10'h3e7;
  localparam logic [5:0] SEC_MAX = 6'h3b;
  localparam logic [5:0] MIN_MAX = 6'h3b;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam int WR_MS = 0;
  localparam int WR_SEC = 1;
  localparam int WR_MIN = 2;
  localparam int WR_HOUR = 3;
  localparam int WR_DAY = 4;

  typedef enum logic [1:0] {
    WS_IDLE = 2'b01,
    WS_BUSY = 2'b10
  } act_wait_state_t;

endpackage

// File: act_cnt_if.sv
`timescale 1ns/10ps
interface act_cnt_if #(parameter int NPINS = 24);
  logic [NPINS-1:0] pin_en;
  logic [NPINS-1:0] pin_fall;
  logic [NPINS-1:0] clr;
  logic [NPINS-1:0][31:0] count;
  modport ctl (output pin_en, output pin_fall, output clr, input count);
  modport bank (input pin_en, input pin_fall, input clr, output count);
endinterface

// File: act_edge_bank.sv
`timescale 1ns/10ps
module act_edge_bank #(
  parameter int NPINS = act_pkg::NPINS
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // pins
  input wire logic [NPINS-1:0] pin_i,
  // control and counts
  act_cnt_if.bank cif
);

  logic [NPINS-1:0] s1;
  logic [NPINS-1:0] s2;
  logic [NPINS-1:0] s3;
  logic [NPINS-1:0] lvl;
  logic [NPINS-1:0] next_lvl;
  logic [NPINS-1:0][31:0] cnt;
  logic [NPINS-1:0][31:0] next_cnt;

  // ----------------------------------------------------------------------
  // per-pin edge detect and count
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NPINS; i++)
    begin : g_pin
      logic edge_seen;
      logic next_pin_lvl;
      logic [31:0] next_pin_cnt;
      always_comb
      begin
        next_pin_lvl = (s2[i] == s3[i]) ? s3[i] : lvl[i];
        // pin must be enabled in pin_en to count
        edge_seen = (s2[i] == s3[i]) && (s3[i] != lvl[i]) &&
                    (s3[i] != cif.pin_fall[i]);
        if (cif.clr[i])
          next_pin_cnt = '0;
        else if (cif.pin_en[i] && edge_seen)
          next_pin_cnt = cnt[i] + 32'h0000_0001;
        else
          next_pin_cnt = cnt[i];
      end
      // one process per pin writes only its own locals; slices join here
      assign next_lvl[i] = next_pin_lvl;
      assign next_cnt[i] = next_pin_cnt;
    end
  endgenerate

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      lvl <= '0;
      cnt <= '0;
    end
    else
    begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      lvl <= next_lvl;
      cnt <= next_cnt;
    end
  end

  assign cif.count = cnt;

endmodule

// File: act_top.sv
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
// Function
// - unset alarm fields are wildcards; only set fields are compared.
// - alarm keeps no year; a written year is dropped.
// - full match of set fields raises the alarm event.
// - writing zero, or all fields empty, clears and disarms the alarm.
// - unset alarm fields, year included, read back as minus one.
// - twenty-four unsigned 32-bit pin edge counters, readable.
// - counter steps by one on its pin's chosen edge.
// - resetting one counter zeroes it and leaves the others alone.
// - counts edge rates of ten kilohertz or more without loss.
// - uptime cascades millis, seconds, minutes, hours, days with carries.
// - total uptime counts every millisecond since reset.
// - uptime reset zeroes all fields; otherwise it runs freely.
// - each uptime field except the total raises a wrap event when it wraps; the total wraps silently.
// - ten countdown timers with one millisecond resolution.
// - reading a timer gives milliseconds left to next expiry.
// - time without repeat runs once, events at expiry, then stops.
// - repeat N expires N times with reload; zero repeats forever.
// - loading time zero stops and clears the timer.
// - wait holds command processing for given milliseconds off the tick; here it only raises wait_busy_o, bus commands still run.
module act_top #(
  parameter int unsigned MS_CYCLES = act_pkg::MS_CYCLES,
  parameter int NPINS = act_pkg::NPINS,
  parameter int NTMR = act_pkg::NTMR
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // counter pins
  input wire logic [NPINS-1:0] pin_i,
  // calendar clock, same clock domain
  input wire logic [7:0] rtc_month_i,
  input wire logic [7:0] rtc_day_i,
  input wire logic [7:0] rtc_hour_i,
  input wire logic [7:0] rtc_min_i,
  input wire logic [7:0] rtc_sec_i,
  // events and status
  output logic alarm_evt_o,
  output logic [4:0] wrap_evt_o,
  output logic [NTMR-1:0] timer_evt_o,
  output logic wait_busy_o
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [31:0] div_cnt;
  logic [31:0] next_div_cnt;
  logic ms_tick;
  logic next_ms_tick;
  logic [11:0] w_off;
  logic [11:0] rel;
  logic wr;
  logic alm_hit;
  logic rt_hit;
  logic tmr_hit;
  logic cnt_hit;
  logic [2:0] alm_idx;
  logic [2:0] rt_idx;
  logic [3:0] tmr_idx;
  logic tmr_rpt;
  logic [4:0] cnt_idx;
  logic [31:0] next_dat;
  logic next_ack;
  logic [NPINS-1:0] pin_en;
  logic [NPINS-1:0] next_pin_en;
  logic [NPINS-1:0] pin_fall;
  logic [NPINS-1:0] next_pin_fall;
  logic [act_pkg::ALM_NF-1:0][7:0] alm_val;
  logic [act_pkg::ALM_NF-1:0][7:0] next_alm_val;
  logic [act_pkg::ALM_NF-1:0] alm_vld;
  logic [act_pkg::ALM_NF-1:0] next_alm_vld;
  logic [act_pkg::ALM_NF-1:0][7:0] rtc_now;
  logic alm_match;
  logic alm_match_q;
  logic next_alm_evt;
  logic [9:0] rt_ms;
  logic [9:0] next_rt_ms;
  logic [5:0] rt_s;
  logic [5:0] next_rt_s;
  logic [5:0] rt_m;
  logic [5:0] next_rt_m;
  logic [4:0] rt_h;
  logic [4:0] next_rt_h;
  logic [31:0] rt_d;
  logic [31:0] next_rt_d;
  logic [31:0] rt_tot;
  logic [31:0] next_rt_tot;
  logic [4:0] next_wrap;
  logic [31:0] tmr_rem [NTMR];
  logic [31:0] next_tmr_rem [NTMR];
  logic [31:0] tmr_per [NTMR];
  logic [31:0] next_tmr_per [NTMR];
  logic [31:0] tmr_runs [NTMR];
  logic [31:0] next_tmr_runs [NTMR];
  logic [31:0] tmr_stage [NTMR];
  logic [31:0] next_tmr_stage [NTMR];
  logic [NTMR-1:0] tmr_on;
  logic [NTMR-1:0] next_tmr_on;
  logic [NTMR-1:0] next_tmr_evt;
  act_pkg::act_wait_state_t wst;
  act_pkg::act_wait_state_t next_wst;
  logic [31:0] wait_rem;
  logic [31:0] next_wait_rem;
  logic next_wait_busy;

  act_cnt_if #(.NPINS(NPINS)) cif ();

  act_edge_bank #(.NPINS(NPINS)) u_bank (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(pin_i),
    .cif(cif)
  );

  // ----------------------------------------------------------------------
  // millisecond tick
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_ms_tick = (div_cnt == 32'(MS_CYCLES - 1));
    next_div_cnt = next_ms_tick ? 32'h0000_0000 : div_cnt + 32'h0000_0001;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_cnt <= '0;
      ms_tick <= 1'b0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      ms_tick <= next_ms_tick;
    end
  end

  // ----------------------------------------------------------------------
  // bus decode and read data
  // ----------------------------------------------------------------------
  // partial-word writes are acknowledged but ignored: every field is a word
  always_comb
  begin
    w_off = {wb_adr_i[11:2], 2'b00};
    wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && (wb_sel_i == 4'hf);
    rel = w_off - act_pkg::OFF_ALM_BASE;
    alm_hit = (w_off >= act_pkg::OFF_ALM_BASE) && (rel < act_pkg::ALM_SPAN);
    alm_idx = rel[4:2];
    rel = w_off - act_pkg::OFF_RT_BASE;
    rt_hit = (w_off >= act_pkg::OFF_RT_BASE) && (rel < act_pkg::RT_SPAN);
    rt_idx = rel[4:2];
    rel = w_off - act_pkg::OFF_TMR_BASE;
    tmr_hit = (w_off >= act_pkg::OFF_TMR_BASE) && (rel < act_pkg::TMR_SPAN);
    tmr_idx = rel[6:3];
    tmr_rpt = rel[2];
    rel = w_off - act_pkg::OFF_CNT_BASE;
    cnt_hit = (w_off >= act_pkg::OFF_CNT_BASE) && (rel < act_pkg::CNT_SPAN);
    cnt_idx = rel[6:2];
    next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_dat = 32'h0000_0000;
    if (alm_hit)
      next_dat = alm_vld[alm_idx] ? {24'h00_0000, alm_val[alm_idx]}
                                  : act_pkg::FIELD_UNSET;
    else if (tmr_hit)
      next_dat = tmr_rpt ? tmr_stage[tmr_idx] : tmr_rem[tmr_idx];
    else if (cnt_hit)
      next_dat = cif.count[cnt_idx];
    else if (rt_hit)
    begin
      unique case (rt_idx)
        3'h0: next_dat = {22'h00_0000, rt_ms};
        3'h1: next_dat = {26'h000_0000, rt_s};
        3'h2: next_dat = {26'h000_0000, rt_m};
        3'h3: next_dat = {27'h000_0000, rt_h};
        3'h4: next_dat = rt_d;
        default: next_dat = rt_tot;
      endcase
    end
    else if (w_off == act_pkg::OFF_STATUS)
    begin
      next_dat[act_pkg::ST_ARMED] = |alm_vld;
      next_dat[act_pkg::ST_WAIT] = wait_busy_o;
    end
    else if (w_off == act_pkg::OFF_WAIT)
      next_dat = wait_rem;
    else if (w_off == act_pkg::OFF_PIN_EN)
      next_dat = 32'(pin_en);
    else if (w_off == act_pkg::OFF_PIN_FALL)
      next_dat = 32'(pin_fall);
    next_pin_en = pin_en;
    next_pin_fall = pin_fall;
    if (wr && w_off == act_pkg::OFF_PIN_EN)
      next_pin_en = wb_dat_i[NPINS-1:0];
    if (wr && w_off == act_pkg::OFF_PIN_FALL)
      next_pin_fall = wb_dat_i[NPINS-1:0];
  end

  always_comb
  begin
    cif.clr = '0;
    if (wr && cnt_hit)
      cif.clr[cnt_idx] = 1'b1;
  end

  assign cif.pin_en = pin_en;
  assign cif.pin_fall = pin_fall;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      pin_en <= '0;
      pin_fall <= '0;
    end
    else
    begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
      pin_en <= next_pin_en;
      pin_fall <= next_pin_fall;
    end
  end

  // ----------------------------------------------------------------------
  // calendar alarm
  // ----------------------------------------------------------------------
  always_comb
  begin
    // index order follows the field offsets: year slot 0, seconds slot 5
    rtc_now = {rtc_sec_i, rtc_min_i, rtc_hour_i, rtc_day_i, rtc_month_i, 8'h00};
    alm_match = |alm_vld;
    for (int f = 1; f < act_pkg::ALM_NF; f++)
      if (alm_vld[f] && alm_val[f] != rtc_now[f])
        alm_match = 1'b0;
    next_alm_evt = alm_match && !alm_match_q;
    next_alm_val = alm_val;
    next_alm_vld = alm_vld;
    if (wr && alm_hit && alm_idx != 3'(act_pkg::ALM_YEAR))
    begin
      next_alm_vld[alm_idx] = (wb_dat_i != act_pkg::FIELD_UNSET);
      next_alm_val[alm_idx] = wb_dat_i[7:0];
    end
    if (wr && w_off == act_pkg::OFF_ALM_CLR && wb_dat_i == 32'h0000_0000)
    begin
      next_alm_vld = '0;
      next_alm_val = '0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      alm_val <= '0;
      alm_vld <= '0;
      alm_match_q <= 1'b0;
      alarm_evt_o <= 1'b0;
    end
    else
    begin
      alm_val <= next_alm_val;
      alm_vld <= next_alm_vld;
      alm_match_q <= alm_match;
      alarm_evt_o <= next_alm_evt;
    end
  end

  // ----------------------------------------------------------------------
  // uptime counter
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_rt_ms = rt_ms;
    next_rt_s = rt_s;
    next_rt_m = rt_m;
    next_rt_h = rt_h;
    next_rt_d = rt_d;
    next_rt_tot = rt_tot;
    next_wrap = '0;
    if (wr && w_off == act_pkg::OFF_CTRL && wb_dat_i[act_pkg::CTRL_RT_RST])
    begin
      next_rt_ms = '0;
      next_rt_s = '0;
      next_rt_m = '0;
      next_rt_h = '0;
      next_rt_d = '0;
      next_rt_tot = '0;
    end
    else if (ms_tick)
    begin
      next_rt_tot = rt_tot + 32'h0000_0001;
      next_rt_ms = rt_ms + 10'h001;
      if (rt_ms == act_pkg::MS_MAX)
      begin
        next_rt_ms = '0;
        next_wrap[act_pkg::WR_MS] = 1'b1;
        next_rt_s = rt_s + 6'h01;
        if (rt_s == act_pkg::SEC_MAX)
        begin
          next_rt_s = '0;
          next_wrap[act_pkg::WR_SEC] = 1'b1;
          next_rt_m = rt_m + 6'h01;
          if (rt_m == act_pkg::MIN_MAX)
          begin
            next_rt_m = '0;
            next_wrap[act_pkg::WR_MIN] = 1'b1;
            next_rt_h = rt_h + 5'h01;
            if (rt_h == act_pkg::HOUR_MAX)
            begin
              next_rt_h = '0;
              next_wrap[act_pkg::WR_HOUR] = 1'b1;
              next_rt_d = rt_d + 32'h0000_0001;
              next_wrap[act_pkg::WR_DAY] = (rt_d == 32'hffff_ffff);
            end
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rt_ms <= '0;
      rt_s <= '0;
      rt_m <= '0;
      rt_h <= '0;
      rt_d <= '0;
      rt_tot <= '0;
      wrap_evt_o <= '0;
    end
    else
    begin
      rt_ms <= next_rt_ms;
      rt_s <= next_rt_s;
      rt_m <= next_rt_m;
      rt_h <= next_rt_h;
      rt_d <= next_rt_d;
      rt_tot <= next_rt_tot;
      wrap_evt_o <= next_wrap;
    end
  end

  // ----------------------------------------------------------------------
  // countdown timers
  // ----------------------------------------------------------------------
  // a load in the same cycle as a tick wins, so the new period starts whole
  always_comb
  begin
    next_tmr_evt = '0;
    next_tmr_on = tmr_on;
    for (int t = 0; t < NTMR; t++)
    begin
      next_tmr_rem[t] = tmr_rem[t];
      next_tmr_per[t] = tmr_per[t];
      next_tmr_runs[t] = tmr_runs[t];
      next_tmr_stage[t] = tmr_stage[t];
      if (wr && tmr_hit && tmr_idx == 4'(t))
      begin
        if (tmr_rpt)
          next_tmr_stage[t] = wb_dat_i;
        else if (wb_dat_i == 32'h0000_0000)
        begin
          next_tmr_on[t] = 1'b0;
          next_tmr_rem[t] = '0;
          next_tmr_runs[t] = '0;
        end
        else
        begin
          next_tmr_on[t] = 1'b1;
          next_tmr_rem[t] = wb_dat_i;
          next_tmr_per[t] = wb_dat_i;
          next_tmr_runs[t] = tmr_stage[t];
          next_tmr_stage[t] = 32'h0000_0001;
        end
      end
      else if (ms_tick && tmr_on[t])
      begin
        if (tmr_rem[t] == 32'h0000_0001)
        begin
          next_tmr_evt[t] = 1'b1;
          if (tmr_runs[t] == 32'h0000_0000)
            next_tmr_rem[t] = tmr_per[t];
          else if (tmr_runs[t] > 32'h0000_0001)
          begin
            next_tmr_rem[t] = tmr_per[t];
            next_tmr_runs[t] = tmr_runs[t] - 32'h0000_0001;
          end
          else
          begin
            next_tmr_on[t] = 1'b0;
            next_tmr_rem[t] = '0;
            next_tmr_runs[t] = '0;
          end
        end
        else
          next_tmr_rem[t] = tmr_rem[t] - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tmr_on <= '0;
      timer_evt_o <= '0;
      for (int t = 0; t < NTMR; t++)
      begin
        tmr_rem[t] <= '0;
        tmr_per[t] <= '0;
        tmr_runs[t] <= '0;
        tmr_stage[t] <= 32'h0000_0001;
      end
    end
    else
    begin
      tmr_on <= next_tmr_on;
      timer_evt_o <= next_tmr_evt;
      tmr_rem <= next_tmr_rem;
      tmr_per <= next_tmr_per;
      tmr_runs <= next_tmr_runs;
      tmr_stage <= next_tmr_stage;
    end
  end

  // ----------------------------------------------------------------------
  // wait delay
  // ----------------------------------------------------------------------
  // command flow does not stall; only wait_busy_o is raised, and counters, timers and events keep running
  always_comb
  begin
    next_wst = wst;
    next_wait_rem = wait_rem;
    unique case (wst)
      act_pkg::WS_IDLE:
      begin
        if (wr && w_off == act_pkg::OFF_WAIT && wb_dat_i != 32'h0000_0000)
        begin
          next_wst = act_pkg::WS_BUSY;
          next_wait_rem = wb_dat_i;
        end
      end
      act_pkg::WS_BUSY:
      begin
        if (ms_tick)
        begin
          next_wait_rem = wait_rem - 32'h0000_0001;
          if (wait_rem == 32'h0000_0001)
            next_wst = act_pkg::WS_IDLE;
        end
      end
      default:
      begin
        next_wst = act_pkg::WS_IDLE;
        next_wait_rem = '0;
      end
    endcase
    next_wait_busy = (next_wst == act_pkg::WS_BUSY);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wst <= act_pkg::WS_IDLE;
      wait_rem <= '0;
      wait_busy_o <= 1'b0;
    end
    else
    begin
      wst <= next_wst;
      wait_rem <= next_wait_rem;
      wait_busy_o <= next_wait_busy;
    end
  end

endmodule

// File: act_top_props.sv
`timescale 1ns/10ps
module act_top_props #(
  parameter int NTMR = 10
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // events
  input wire logic alarm_evt_o,
  input wire logic [4:0] wrap_evt_o,
  input wire logic [NTMR-1:0] timer_evt_o,
  input wire logic wait_busy_o
);
  // ----------------------------------------------------------------------
  // bus and event timing
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked next cycle");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 12'hffc |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_alarm_one_pulse: assert property (alarm_evt_o |=> !alarm_evt_o)
    else $error("alarm event repeated");
  a_timer_one_pulse: assert property ((timer_evt_o != '0) |=> (timer_evt_o & $past(timer_evt_o)) == '0)
    else $error("timer event longer than one cycle");
  a_wrap_ms_spaced: assert property (wrap_evt_o[0] |=> !wrap_evt_o[0] [*8])
    else $error("millis wrap events too close");
  a_wait_from_write: assert property ($rose(wait_busy_o) |-> $past(wb_ack_o && wb_we_i) && $past(wb_adr_i[11:2]) == 10'h002)
    else $error("wait started without wait write");

  // keeps the main scenarios visible in coverage
  c_alarm: cover property (alarm_evt_o);
  c_timer: cover property (timer_evt_o[0]);
  c_wait: cover property ($fell(wait_busy_o));
endmodule

// File: act_top_tb_top.sv
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module act_top_tb_top;
  localparam int NTMR = 10;
  logic sys_clk_i = 0;
  logic rst_n_i = 0;
  logic wb_cyc_i = 0;
  logic wb_stb_i = 0;
  logic wb_we_i = 0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [23:0] pin_i = 24'h0;
  logic [7:0] rtc_sec_i = 8'h00;
  logic [7:0] rtc_min_i = 8'h00;
  logic [7:0] rtc_hour_i = 8'h00;
  logic alarm_evt_o;
  logic [4:0] wrap_evt_o;
  logic [NTMR-1:0] timer_evt_o;
  logic wait_busy_o;
  logic [31:0] rd;
  int fail_count = 0;
  int checks = 0;
  int acnt = 0;
  int tev[4] = '{0, 0, 0, 0};
  int n;

  act_top #(.MS_CYCLES(10)) dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_i(pin_i), .rtc_month_i(8'h00),
    .rtc_day_i(8'h00), .rtc_hour_i(rtc_hour_i), .rtc_min_i(rtc_min_i), .rtc_sec_i(rtc_sec_i),
    .alarm_evt_o(alarm_evt_o), .wrap_evt_o(wrap_evt_o), .timer_evt_o(timer_evt_o),
    .wait_busy_o(wait_busy_o));

  initial
  begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i)
  begin
    if (alarm_evt_o === 1'b1) acnt++;
    for (int i = 0; i < 4; i++) if (timer_evt_o[i] === 1'b1) tev[i]++;
  end

  // ----------------------------------------------------------------------
  // bus and closing
  // ----------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // entered just after a rising edge; holds the request until ack is sampled
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    k = 0;
    do begin @(posedge sys_clk_i); k++; end while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      fail_count++;
      report_and_stop();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    wb(0, 12'h004, 0); `CHK(rd, 32'h0)
    wb(0, 12'h020, 0); `CHK(rd, 32'hffff_ffff)
    wb(0, 12'h114, 0); `CHK(rd, 32'h0)
    wb(0, 12'h080, 0); `CHK(rd, 32'h0)
    wb(0, 12'hffc, 0); `CHK(rd, 32'h0)
  endtask

  task automatic t_alarm();
    wb(1, 12'h034, 5);
    wb(0, 12'h004, 0); `CHK(rd[0], 1'b1)
    wb(0, 12'h024, 0); `CHK(rd, 32'hffff_ffff)
    wb(0, 12'h034, 0); `CHK(rd, 32'h5)
    rtc_sec_i <= 8'h05;
    repeat (6) @(posedge sys_clk_i);
    `CHK(acnt, 1)
    rtc_min_i <= 8'h09;
    repeat (6) @(posedge sys_clk_i);
    `CHK(acnt, 1)
    rtc_sec_i <= 8'h06;
    repeat (3) @(posedge sys_clk_i);
    rtc_sec_i <= 8'h05;
    repeat (6) @(posedge sys_clk_i);
    `CHK(acnt, 2)
    wb(1, 12'h020, 7);
    wb(0, 12'h020, 0); `CHK(rd, 32'hffff_ffff)
    wb(1, 12'h02c, 3);
    rtc_sec_i <= 8'h06;
    repeat (3) @(posedge sys_clk_i);
    rtc_sec_i <= 8'h05;
    repeat (6) @(posedge sys_clk_i);
    `CHK(acnt, 2)
    rtc_hour_i <= 8'h03;
    repeat (6) @(posedge sys_clk_i);
    `CHK(acnt, 3)
    wb(1, 12'h00c, 0);
    wb(0, 12'h004, 0); `CHK(rd[0], 1'b0)
    wb(0, 12'h02c, 0); `CHK(rd, 32'hffff_ffff)
    rtc_sec_i <= 8'h06;
    repeat (3) @(posedge sys_clk_i);
    rtc_sec_i <= 8'h05;
    repeat (6) @(posedge sys_clk_i);
    `CHK(acnt, 3)
  endtask

  task automatic t_pins();
    wb(1, 12'h180, 3);
    wb(1, 12'h184, 2);
    // pin 2 toggles too but stays disabled
    for (int k = 0; k < 3; k++)
    begin
      pin_i <= 24'h7;
      repeat (5) @(posedge sys_clk_i);
      pin_i <= 24'h0;
      repeat (5) @(posedge sys_clk_i);
    end
    wb(0, 12'h100, 0); `CHK(rd, 32'h3)
    wb(0, 12'h104, 0); `CHK(rd, 32'h3)
    wb(0, 12'h108, 0); `CHK(rd, 32'h0)
    wb(1, 12'h100, 1);
    wb(0, 12'h100, 0); `CHK(rd, 32'h0)
    wb(0, 12'h104, 0); `CHK(rd, 32'h3)
  endtask

  task automatic t_timers();
    // repeat stage is staged before the time load that uses it
    wb(1, 12'h084, 3);
    wb(1, 12'h080, 2);
    wb(1, 12'h088, 4);
    wb(1, 12'h09c, 0);
    wb(1, 12'h098, 1);
    wb(1, 12'h090, 5);
    wb(0, 12'h090, 0); `CHK(rd >= 4 && rd <= 5, 1'b1)
    repeat (150) @(posedge sys_clk_i);
    `CHK(tev[0], 3)
    `CHK(tev[1], 1)
    `CHK(tev[2], 1)
    `CHK(tev[3] > 10, 1'b1)
    wb(0, 12'h080, 0); `CHK(rd, 32'h0)
    wb(1, 12'h098, 0);
    n = tev[3];
    repeat (50) @(posedge sys_clk_i);
    `CHK(tev[3], n)
    wb(0, 12'h098, 0); `CHK(rd, 32'h0)
  endtask

  task automatic t_wait();
    wb(1, 12'h008, 3);
    `CHK(wait_busy_o, 1'b1)
    n = 0;
    while (wait_busy_o === 1'b1 && n < 100)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    `CHK(n >= 18 && n <= 32, 1'b1)
  endtask

  task automatic t_uptime();
    wb(1, 12'h000, 1);
    n = 0;
    while (wrap_evt_o[0] !== 1'b1 && n < 12000)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    `CHK(n >= 9990 && n <= 10000, 1'b1)
    @(posedge sys_clk_i);
    wb(0, 12'h044, 0); `CHK(rd, 32'h1)
    wb(0, 12'h054, 0); `CHK(rd >= 1000 && rd <= 1001, 1'b1)
  endtask

  initial
  begin
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    t_reset();
    t_alarm();
    t_pins();
    t_timers();
    t_wait();
    t_uptime();
    report_and_stop();
  end
endmodule

bind act_top act_top_props #(.NTMR(NTMR)) u_props (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .alarm_evt_o(alarm_evt_o), .wrap_evt_o(wrap_evt_o), .timer_evt_o(timer_evt_o),
  .wait_busy_o(wait_busy_o));
